// ==== src/cdo_pkg.sv ====
// Shared constants and types for the capacitive detection and output configuration block.
package cdo_pkg;
  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned MS_TIME   = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
  localparam int unsigned MS_PER_S  = 1000;

  // Field positions of sensitivity_scan_config.
  localparam int BASE_MSB  = 7;
  localparam int BASE_LSB  = 6;
  localparam int SCAN_MSB  = 5;
  localparam int SCAN_LSB  = 4;
  localparam int WAKE_BIT  = 3;
  localparam int SLEEP_MSB = 2;
  localparam int SLEEP_LSB = 0;

  // Field positions of threshold_config.
  localparam int LATE_BIT  = 7;
  localparam int PROX_MSB  = 6;
  localparam int PROX_LSB  = 5;
  localparam int TOUCH_MSB = 4;
  localparam int TOUCH_LSB = 2;
  localparam int MOV_MSB   = 1;
  localparam int MOV_LSB   = 0;

  // Field positions of timer_output_config.
  localparam int NOMOV_MSB = 7;
  localparam int NOMOV_LSB = 5;
  localparam int TYPE_MSB  = 4;
  localparam int TYPE_LSB  = 3;
  localparam int UI_MSB    = 2;
  localparam int UI_LSB    = 0;

  localparam logic [1:0] MOV_PFM       = 2'h0;
  localparam logic [1:0] MOV_PWM       = 2'h1;
  localparam logic [1:0] MOV_LATCH     = 2'h2;
  localparam logic [1:0] MOV_PFM_GATED = 2'h3;

  localparam logic [2:0] UI_ACT_MOV    = 3'h0;
  localparam logic [2:0] UI_LATCH_MOV  = 3'h1;
  localparam logic [2:0] UI_MOV_INPUT  = 3'h2;
  localparam logic [2:0] UI_PROX_TOUCH = 3'h3;

  // Scan periods in ms, detection thresholds and timers.
  localparam logic [7:0] IDLE_MS   [4] = '{8'h14, 8'h28, 8'h0a, 8'h32};
  localparam logic [7:0] ACTIVE_MS [4] = '{8'h14, 8'h14, 8'h0a, 8'h28};
  localparam logic [7:0] SLEEP_MS  [8] = '{8'h10, 8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc8, 8'hfa};
  localparam logic [7:0] PROX_CNT  [4] = '{8'h04, 8'h08, 8'h10, 8'h20};
  localparam logic [6:0] TOUCH_PCT [8] = '{7'h01, 7'h02, 7'h03, 7'h05, 7'h07, 7'h08, 7'h14, 7'h5a};
  localparam logic [7:0] MOV_CNT   [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
  localparam logic [7:0] NOMOV_S   [8] = '{8'h01, 8'h02, 8'h05, 8'h0a, 8'h14, 8'h1e, 8'h3c, 8'h78};

  localparam logic [6:0]  TOUCH_LEVEL_PCT = 7'h08;
  localparam logic [1:0]  PROX_DEBOUNCE   = 2'h2;
  localparam logic [23:0] PCT_SCALE       = 24'h000064;
  localparam logic [11:0] ENV_CHANGE_CNT  = 12'h040;
  localparam logic [15:0] IDLE_HOLD_MS    = 16'h03e8;
  localparam logic [3:0]  PFM_PULSE_MS    = 4'ha;
  localparam logic [7:0]  PFM_PERIOD_MS   = 8'h14;
  localparam logic [7:0]  INTENSITY_SAT   = 8'hff;
  localparam logic [7:0]  INTENSITY_TOP   = 8'hfe;
  localparam int unsigned PWM_STEPS       = 256;

  typedef enum logic [1:0] {CDO_SLEEP, CDO_IDLE, CDO_ACTIVE} cdo_scan_e;
endpackage

// ==== src/cdo_cap_detect.sv ====
// Detection, scan-time control and output encoding of the capacitive proximity/touch channel.
// Operation
// - Two-bit base sets sensitivity; lower base gives higher sensitivity.
// - Two-bit idle/active scan-time pair and three-bit sleep scan time.
// - Active direction: leave sleep for idle only on a real proximity event.
// - Both directions: a large environmental change also wakes to idle.
// - Both directions: covered time-out plus recalibration keeps a stale reference, no sleep.
// - Late release: assert at touch threshold, release below half of it.
// - Proximity threshold exceeded halts the drift-tracking filters.
// - Proximity drives a pin only in the proximity-and-touch interface.
// - Three-bit touch threshold in percent of average sets activation.
// - Proximity levels debounce over two samples; touch levels act on one.
// - Two-bit movement threshold in counts decides movement detection.
// - No-movement timer clears activation in the applicable interfaces.
// - Movement goes to secondary pin, or primary pin in movement-input interface; to no pin in proximity-and-touch interface.
// - Type 00 emits low pulses, densest 10 ms wide at 20 ms period.
// - Saturated movement in pulse-density mode holds the output low.
// - Type 01 gives a 1 kHz pulse-width signal following intensity.
// - Type 10 latches on first movement, clears after no-movement period.
// - Type 11 is pulse-density output only while activation holds.
`timescale 1ns/1ps
module cdo_cap_detect #(
  parameter int unsigned MS_CYCLES = cdo_pkg::MS_CYCLES
) (
  input  wire logic        clk,                     // System clock, 25 MHz.
  input  wire logic        rst_b,                   // Asynchronous reset, active low.
  input  wire logic [7:0]  sensitivity_scan_config, // Base, scan times and wake direction.
  input  wire logic [7:0]  threshold_config,        // Late release and thresholds.
  input  wire logic [7:0]  timer_output_config,     // Timer, movement type, interface.
  input  wire logic        sample_valid,            // One-cycle strobe of a new conversion.
  input  wire logic [11:0] touch_delta,             // Signed delta from long_term_average.
  input  wire logic [15:0] long_term_average,       // Reference counts.
  input  wire logic [7:0]  movement_delta,          // Delta counts from movement average.
  input  wire logic        recal_done,              // One-cycle strobe after a recalibration.
  input  wire logic        secondary_io_pin_i,      // Secondary pin level from the pad.
  output logic             conversion_start,        // One-cycle request to convert.
  output logic [1:0]       sense_base,              // Base value to the front end.
  output cdo_pkg::cdo_scan_e scan_mode,             // Current scan-time mode.
  output logic             filter_halt,             // Halts drift tracking.
  output logic             primary_output_pin_o,    // Primary pin drive level.
  output logic             primary_output_pin_oe,   // Primary pin drive enable.
  output logic             secondary_io_pin_o,      // Secondary pin drive level.
  output logic             secondary_io_pin_oe,     // Secondary pin drive enable.
  output logic             host_input_level         // Synchronised secondary pin level.
);
  if (MS_CYCLES < cdo_pkg::PWM_STEPS || MS_CYCLES > 65536)
  begin : g_chk
    $error("MS_CYCLES must lie between 256 and 65536");
  end

  localparam logic [15:0] MS_LAST  = 16'(MS_CYCLES - 1);
  localparam logic [23:0] PWM_STEP = 24'(MS_CYCLES / cdo_pkg::PWM_STEPS);
  localparam logic [12:0] PFM_FULL = 13'(cdo_pkg::PFM_PERIOD_MS) * 13'(cdo_pkg::INTENSITY_TOP);

  typedef struct packed {
    cdo_pkg::cdo_scan_e scan;
    logic [15:0] ms_cnt;
    logic [7:0]  scan_cnt;
    logic        conv;
    logic [1:0]  t_hits;
    logic [1:0]  p_hits;
    logic        act;
    logic        block;
    logic        prox;
    logic [16:0] nomov;
    logic        expire;
    logic        latch;
    logic        cover_to;
    logic        stale;
    logic [15:0] idle_cnt;
    logic        mov_det;
    logic [7:0]  intensity;
    logic        sat;
    logic [12:0] pfm_acc;
    logic [3:0]  pfm_cnt;
    logic        mov_low;
    logic        p_low;
    logic        p_oe;
    logic        s_low;
    logic        s_oe;
    logic        sync1;
    logic        sync2;
  } cdo_state_s;

  cdo_state_s q;
  cdo_state_s d;

  logic [1:0]  base;
  logic        both_dir;
  logic        late;
  logic [6:0]  pct;
  logic [1:0]  need;
  logic [1:0]  mtype;
  logic [2:0]  ui;
  logic [11:0] delta_pos;
  logic [11:0] eff;
  logic        prox_over;
  logic        touch_over;
  logic        hold_over;
  logic        env_change;
  logic        mov_now;
  logic        ms_tick;
  logic [7:0]  period;
  logic [16:0] nomov_lim;
  logic        pfm_start;
  logic        pfm_low;
  logic        pwm_low;
  logic        mov_level;
  logic        act_ui;

  assign base     = sensitivity_scan_config[cdo_pkg::BASE_MSB:cdo_pkg::BASE_LSB];
  assign both_dir = sensitivity_scan_config[cdo_pkg::WAKE_BIT];
  assign late     = threshold_config[cdo_pkg::LATE_BIT];
  assign pct      = cdo_pkg::TOUCH_PCT[threshold_config[cdo_pkg::TOUCH_MSB:cdo_pkg::TOUCH_LSB]];
  assign mtype    = timer_output_config[cdo_pkg::TYPE_MSB:cdo_pkg::TYPE_LSB];
  assign ui       = timer_output_config[cdo_pkg::UI_MSB:cdo_pkg::UI_LSB];
  assign act_ui   = (ui == cdo_pkg::UI_ACT_MOV) || (ui == cdo_pkg::UI_LATCH_MOV);

  // A negative delta means the sensor moved away from the reference and never counts toward a proximity or touch trigger.
  assign delta_pos  = touch_delta[11] ? 12'h000 : touch_delta;
  assign eff        = delta_pos >> base;
  assign prox_over  = {4'h0, eff} >= {4'h0, cdo_pkg::PROX_CNT[threshold_config[cdo_pkg::PROX_MSB:cdo_pkg::PROX_LSB]]};
  assign touch_over = 24'(eff) * cdo_pkg::PCT_SCALE >= 24'(long_term_average) * 24'(pct);
  assign hold_over  = late ? (24'(eff) * cdo_pkg::PCT_SCALE * 24'h000002 >= 24'(long_term_average) * 24'(pct))
                           : touch_over;
  assign env_change = touch_delta[11] && (12'(~touch_delta + 12'h001) >= cdo_pkg::ENV_CHANGE_CNT);
  assign need       = (pct < cdo_pkg::TOUCH_LEVEL_PCT) ? cdo_pkg::PROX_DEBOUNCE : 2'h1;
  assign mov_now    = movement_delta >= cdo_pkg::MOV_CNT[threshold_config[cdo_pkg::MOV_MSB:cdo_pkg::MOV_LSB]];
  assign ms_tick    = q.ms_cnt == MS_LAST;
  assign nomov_lim  = 17'(cdo_pkg::NOMOV_S[timer_output_config[cdo_pkg::NOMOV_MSB:cdo_pkg::NOMOV_LSB]])
                      * 17'(cdo_pkg::MS_PER_S);
  assign pfm_start  = ms_tick && (q.pfm_cnt == 4'h0) && (q.pfm_acc >= PFM_FULL);
  assign pfm_low    = (q.pfm_cnt != 4'h0) || q.sat;
  assign pwm_low    = 24'(q.ms_cnt) < 24'(q.intensity) * PWM_STEP;

  always_comb
  begin
    unique case (q.scan)
      cdo_pkg::CDO_SLEEP:  period = cdo_pkg::SLEEP_MS[sensitivity_scan_config[cdo_pkg::SLEEP_MSB:cdo_pkg::SLEEP_LSB]];
      cdo_pkg::CDO_IDLE:   period = cdo_pkg::IDLE_MS[sensitivity_scan_config[cdo_pkg::SCAN_MSB:cdo_pkg::SCAN_LSB]];
      cdo_pkg::CDO_ACTIVE: period = cdo_pkg::ACTIVE_MS[sensitivity_scan_config[cdo_pkg::SCAN_MSB:cdo_pkg::SCAN_LSB]];
      default:             period = cdo_pkg::SLEEP_MS[0];
    endcase
  end

  always_comb
  begin
    unique case (mtype)
      cdo_pkg::MOV_PFM:       mov_level = pfm_low;
      cdo_pkg::MOV_PWM:       mov_level = pwm_low;
      cdo_pkg::MOV_LATCH:     mov_level = q.latch;
      cdo_pkg::MOV_PFM_GATED: mov_level = pfm_low && q.act;
    endcase
  end

  always_comb
  begin
    d        = q;
    d.conv   = 1'b0;
    d.expire = 1'b0;
    d.sync1  = secondary_io_pin_i;
    d.sync2  = q.sync1;
    d.ms_cnt = ms_tick ? 16'h0000 : q.ms_cnt + 16'h0001;

    if (ms_tick)
    begin
      if (q.scan_cnt >= period - 8'h01)
      begin
        d.scan_cnt = 8'h00;
        d.conv     = 1'b1;
      end
      else
      begin
        d.scan_cnt = q.scan_cnt + 8'h01;
      end
      // Movement silence timer; its expiry ends latched movement and, in the UI_ACT_MOV and UI_LATCH_MOV interfaces, long activations.
      if (q.mov_det)
      begin
        d.nomov = 17'h00000;
      end
      else if (q.nomov >= nomov_lim - 17'h00001)
      begin
        d.nomov  = 17'h00000;
        d.expire = 1'b1;
      end
      else
      begin
        d.nomov = q.nomov + 17'h00001;
      end
      d.idle_cnt = q.prox ? 16'h0000 : q.idle_cnt + 16'h0001;
      // Density accumulator: at the top intensity a pulse starts every 20 ms.
      if (q.intensity == 8'h00)
      begin
        d.pfm_acc = 13'h0000;
      end
      else
      begin
        d.pfm_acc = (pfm_start ? q.pfm_acc - PFM_FULL : q.pfm_acc) + 13'(q.intensity);
      end
      if (pfm_start)
      begin
        d.pfm_cnt = cdo_pkg::PFM_PULSE_MS;
      end
      else if (q.pfm_cnt != 4'h0)
      begin
        d.pfm_cnt = q.pfm_cnt - 4'h1;
      end
    end

    if (sample_valid)
    begin
      d.prox      = prox_over;
      d.mov_det   = mov_now;
      d.intensity = mov_now ? movement_delta : 8'h00;
      d.sat       = mov_now && (movement_delta == cdo_pkg::INTENSITY_SAT);
      d.t_hits    = touch_over ? ((q.t_hits < need) ? q.t_hits + 2'h1 : q.t_hits) : 2'h0;
      d.p_hits    = prox_over ? ((q.p_hits < need) ? q.p_hits + 2'h1 : q.p_hits) : 2'h0;
      if (!touch_over)
      begin
        d.block = 1'b0;
      end
      if (!q.act && !q.block && touch_over && (q.t_hits + 2'h1 >= need))
      begin
        d.act = 1'b1;
      end
      else if (q.act && !hold_over)
      begin
        d.act = 1'b0;
      end
      if (mov_now)
      begin
        d.latch = 1'b1;
      end
    end

    if (q.expire)
    begin
      d.latch = sample_valid && mov_now;
      if (act_ui && q.act)
      begin
        d.act   = 1'b0;
        d.block = 1'b1;
        if (both_dir)
        begin
          d.cover_to = 1'b1;
        end
      end
    end
    if (recal_done && q.cover_to)
    begin
      d.stale    = 1'b1;
      d.cover_to = 1'b0;
    end
    if (!both_dir)
    begin
      d.stale    = 1'b0;
      d.cover_to = 1'b0;
    end

    unique case (q.scan)
      cdo_pkg::CDO_SLEEP:
      begin
        if (q.p_hits >= need || q.t_hits >= need)
        begin
          d.scan = cdo_pkg::CDO_IDLE;
        end
        else if (both_dir && sample_valid && env_change)
        begin
          d.scan = cdo_pkg::CDO_IDLE;
        end
      end
      cdo_pkg::CDO_IDLE:
      begin
        if (q.act)
        begin
          d.scan = cdo_pkg::CDO_ACTIVE;
        end
        else if (q.idle_cnt >= cdo_pkg::IDLE_HOLD_MS && !q.stale)
        begin
          d.scan = cdo_pkg::CDO_SLEEP;
        end
      end
      cdo_pkg::CDO_ACTIVE:
      begin
        if (!q.act)
        begin
          d.scan = cdo_pkg::CDO_IDLE;
        end
      end
      default: d.scan = cdo_pkg::CDO_SLEEP;
    endcase
    if (d.scan != q.scan)
    begin
      d.idle_cnt = 16'h0000;
      d.scan_cnt = 8'h00;
    end

    d.mov_low = mov_level;
    d.p_oe    = 1'b1;
    d.s_oe    = 1'b1;
    d.p_low   = q.act;
    d.s_low   = q.mov_low;
    if (ui == cdo_pkg::UI_MOV_INPUT)
    begin
      d.p_low = q.mov_low;
      d.s_oe  = 1'b0;
      d.s_low = 1'b0;
    end
    else if (ui == cdo_pkg::UI_PROX_TOUCH)
    begin
      d.s_low = q.prox;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
  assign conversion_start      = q.conv;
  assign sense_base            = base;
  assign scan_mode             = q.scan;
  assign filter_halt           = q.prox;
  assign primary_output_pin_o  = ~q.p_low;
  assign primary_output_pin_oe = q.p_oe;
  assign secondary_io_pin_o    = ~q.s_low;
  assign secondary_io_pin_oe   = q.s_oe;
  assign host_input_level      = q.sync2;
  late_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(q.act) && !$past(q.expire) |-> $past(sample_valid) && !$past(hold_over))
    else $error("activation released above the release threshold");
  filter_halt_a: assert property (@(posedge clk) disable iff (!rst_b)
    sample_valid |=> filter_halt == $past(prox_over))
    else $error("filter halt does not follow the proximity threshold");
  prox_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 $past(ui) != cdo_pkg::UI_PROX_TOUCH && $past(ui) != cdo_pkg::UI_MOV_INPUT
    |-> primary_output_pin_o == !$past(q.act))
    else $error("primary pin not driven by activation");
  debounce_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(q.act) && $past(pct) < cdo_pkg::TOUCH_LEVEL_PCT |-> $past(q.t_hits) != 2'h0)
    else $error("proximity level activated without two samples");
  route_a: assert property (@(posedge clk) disable iff (!rst_b)
    $past(ui) == cdo_pkg::UI_MOV_INPUT |-> !secondary_io_pin_oe && primary_output_pin_o == !$past(q.mov_low))
    else $error("movement not routed to the primary pin");
  pfm_width_a: assert property (@(posedge clk) disable iff (!rst_b)
    pfm_start |=> q.pfm_cnt == cdo_pkg::PFM_PULSE_MS ##1 q.pfm_cnt == cdo_pkg::PFM_PULSE_MS)
    else $error("pulse-density pulse has wrong width");
  sat_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    q.sat && mtype == cdo_pkg::MOV_PFM |=> q.mov_low)
    else $error("saturated movement not held low");
  latch_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    q.expire && !(sample_valid && mov_now) |=> !q.latch)
    else $error("latched movement not cleared by the timer");
  gated_a: assert property (@(posedge clk) disable iff (!rst_b)
    mtype == cdo_pkg::MOV_PFM_GATED && !q.act |=> !q.mov_low)
    else $error("gated pulse-density output active without activation");
  wake_a: assert property (@(posedge clk) disable iff (!rst_b)
    q.scan == cdo_pkg::CDO_SLEEP && !both_dir ##1 q.scan == cdo_pkg::CDO_IDLE
    |-> $past(q.p_hits) >= $past(need) || $past(q.t_hits) >= $past(need))
    else $error("left sleep without a proximity event");
endmodule

// ==== verification/cdo_host_model.sv ====
// Host microcontroller model that reads both output pins and can drive the secondary pin.
`timescale 1ns/1ps
module cdo_host_model (
  input  wire logic primary_o,       // Device drive level on the primary pin.
  input  wire logic primary_oe,      // Device drive enable on the primary pin.
  input  wire logic secondary_o,     // Device drive level on the secondary pin.
  input  wire logic secondary_oe,    // Device drive enable on the secondary pin.
  input  wire logic host_drive_en,   // Host drives the secondary pin.
  input  wire logic host_drive,      // Level that the host drives.
  output logic      primary_level,   // Resolved primary pin level.
  output logic      secondary_level  // Resolved secondary pin level.
);
  // Both pins carry pull-ups, so an undriven pin reads high.
  // The host never selects power-up auto-activation, so it owes no partial tuning setting.
  always_comb
  begin
    primary_level   = primary_oe ? primary_o : 1'b1;
    secondary_level = secondary_oe ? secondary_o : (host_drive_en ? host_drive : 1'b1);
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking testbench of the capacitive detection and output block.
`timescale 1ns/1ps
module tb_top;
  localparam int MS = 256;
  logic               clk;
  logic               rst_b;
  logic [7:0]         ssc;
  logic [7:0]         thc;
  logic [7:0]         toc;
  logic               sample_valid;
  logic [11:0]        touch_delta;
  logic [7:0]         movement_delta;
  logic               drv_en;
  logic               drv;
  logic               cs;
  logic [1:0]         base;
  cdo_pkg::cdo_scan_e scan;
  logic               halt;
  logic               p_o;
  logic               p_oe;
  logic               s_o;
  logic               s_oe;
  logic               hin;
  logic               pri;
  logic               sec;
  int                 miscompares;
  int                 total_checks;
  int                 n;
  int                 lows;
  int                 run;

  cdo_cap_detect #(.MS_CYCLES(MS)) i_cdo_cap_detect (
    .clk(clk), .rst_b(rst_b), .sensitivity_scan_config(ssc), .threshold_config(thc),
    .timer_output_config(toc), .sample_valid(sample_valid), .touch_delta(touch_delta),
    .long_term_average(16'h03e8), .movement_delta(movement_delta), .recal_done(1'b0),
    .secondary_io_pin_i(sec), .conversion_start(cs), .sense_base(base), .scan_mode(scan),
    .filter_halt(halt), .primary_output_pin_o(p_o), .primary_output_pin_oe(p_oe),
    .secondary_io_pin_o(s_o), .secondary_io_pin_oe(s_oe), .host_input_level(hin)
  );

  cdo_host_model i_cdo_host_model (
    .primary_o(p_o), .primary_oe(p_oe), .secondary_o(s_o), .secondary_oe(s_oe),
    .host_drive_en(drv_en), .host_drive(drv), .primary_level(pri), .secondary_level(sec)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Presents one conversion; returns at the falling edge after the sampling edge.
  task automatic smp(input logic [11:0] d, input logic [7:0] m);
    @(negedge clk);
    touch_delta = d;
    movement_delta = m;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
  endtask

  task automatic cfg(input logic [7:0] s, input logic [7:0] t, input logic [7:0] o);
    @(negedge clk);
    ssc = s;
    thc = t;
    toc = o;
  endtask

  task automatic rst();
    @(negedge clk);
    rst_b = 1'b0;
    touch_delta = 12'h000;
    movement_delta = 8'h00;
    wt(2);
    rst_b = 1'b1;
    wt(1);
  endtask

  // Counts low cycles of the secondary pin and its longest low run.
  task automatic count_low(input int k);
    int cur;
    lows = 0;
    run = 0;
    cur = 0;
    repeat (k)
    begin
      wt(1);
      cur = (sec === 1'b0) ? cur + 1 : 0;
      lows = (sec === 1'b0) ? lows + 1 : lows;
      run = (cur > run) ? cur : run;
    end
  endtask

  task automatic wait_cs();
    n = 0;
    do
    begin
      wt(1);
      n++;
    end while (cs !== 1'b1 && n < 300 * MS);
    if (cs !== 1'b1)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  initial
  begin
    miscompares = 0;
    total_checks = 0;
    rst_b = 1'b0;
    ssc = 8'h00;
    thc = 8'h17;
    toc = 8'h10;
    sample_valid = 1'b0;
    touch_delta = 12'h000;
    movement_delta = 8'h00;
    drv_en = 1'b0;
    drv = 1'b1;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    wt(2);
    chk(pri, 1'b1);
    chk(sec, 1'b1);
    chk(scan, cdo_pkg::CDO_SLEEP);
    for (int b = 0; b < 4; b++)
    begin
      @(negedge clk);
      ssc = 8'(b << 6);
      #1 chk(base, b);
    end
    $display("test reset_and_base done");

    cfg(8'h00, 8'h17, 8'h10);
    smp(12'hf9c, 8'h00);
    wt(3);
    chk(scan, cdo_pkg::CDO_SLEEP);
    cfg(8'h08, 8'h17, 8'h10);
    smp(12'hf9c, 8'h00);
    wt(3);
    chk(scan, cdo_pkg::CDO_IDLE);
    $display("test wake_direction done");

    rst();
    smp(12'h064, 8'h00);
    chk(pri, 1'b1);
    wt(1);
    chk(halt, 1'b1);
    chk(pri, 1'b0);
    wt(1);
    chk(scan !== cdo_pkg::CDO_SLEEP, 1'b1);
    smp(12'h032, 8'h00);
    wt(3);
    chk(pri, 1'b1);
    smp(12'h064, 8'h00);
    cfg(8'h00, 8'h97, 8'h10);
    smp(12'h032, 8'h00);
    wt(3);
    chk(pri, 1'b0);
    smp(12'h01e, 8'h00);
    wt(3);
    chk(pri, 1'b1);
    cfg(8'h40, 8'h17, 8'h10);
    smp(12'h064, 8'h00);
    wt(3);
    chk(pri, 1'b1);
    $display("test touch_and_release done");

    rst();
    cfg(8'h00, 8'h03, 8'h10);
    smp(12'h032, 8'h00);
    smp(12'h000, 8'h00);
    wt(3);
    chk(pri, 1'b1);
    smp(12'h032, 8'h00);
    smp(12'h032, 8'h00);
    wt(3);
    chk(pri, 1'b0);
    $display("test debounce done");

    rst();
    cfg(8'h00, 8'h17, 8'h10);
    smp(12'h000, 8'h03);
    wt(4);
    chk(sec, 1'b1);
    smp(12'h000, 8'h10);
    wt(4);
    chk(sec, 1'b0);
    chk(pri, 1'b1);
    wt(5 * MS);
    chk(sec, 1'b0);
    cfg(8'h00, 8'h17, 8'h12);
    drv_en = 1'b1;
    drv = 1'b0;
    wt(3);
    chk(pri, 1'b0);
    chk(s_oe, 1'b0);
    chk(hin, 1'b0);
    drv = 1'b1;
    wt(3);
    chk(hin, 1'b1);
    drv_en = 1'b0;
    $display("test movement_latch_routing done");

    rst();
    cfg(8'h00, 8'h1f, 8'h13);
    smp(12'h032, 8'h00);
    smp(12'h032, 8'h00);
    wt(4);
    chk(sec, 1'b0);
    chk(pri, 1'b1);
    cfg(8'h00, 8'h1f, 8'h10);
    wt(3);
    chk(sec, 1'b1);
    $display("test proximity_output done");

    rst();
    cfg(8'h00, 8'h17, 8'h00);
    smp(12'h000, 8'hff);
    wt(4);
    count_low(2 * MS);
    chk(lows, 2 * MS);
    rst();
    smp(12'h000, 8'hfe);
    count_low(60 * MS);
    chk(run, 10 * MS);
    rst();
    cfg(8'h00, 8'h17, 8'h08);
    smp(12'h000, 8'h80);
    wt(2 * MS);
    count_low(4 * MS);
    chk(lows, 4 * 128 * MS / 256);
    rst();
    cfg(8'h00, 8'h17, 8'h18);
    smp(12'h000, 8'hff);
    wt(2 * MS);
    chk(sec, 1'b1);
    smp(12'h064, 8'hff);
    wt(2 * MS);
    chk(sec, 1'b0);
    $display("test movement_types done");

    rst();
    cfg(8'h00, 8'h17, 8'h10);
    wait_cs();
    wait_cs();
    chk(n, 16 * MS);
    cfg(8'h01, 8'h17, 8'h10);
    wait_cs();
    wait_cs();
    chk(n, 32 * MS);
    $display("test scan_period done");
    finish_test();
  end
endmodule
